/* src/fic_regs.svh */
// register offsets, field masks and reset values of the interrupt write ports
`ifndef FIC_REGS_SVH
`define FIC_REGS_SVH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define FIC_ADDR_W      12
`define FIC_NIRQ        39

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FIC_EN_SET_LO   12'h100
`define FIC_EN_SET_HI   12'h104
`define FIC_EN_CLR_LO   12'h180
`define FIC_EN_CLR_HI   12'h184
`define FIC_PD_SET_LO   12'h200
`define FIC_PD_SET_HI   12'h204
`define FIC_PD_CLR_LO   12'h280
`define FIC_PD_CLR_HI   12'h284
`define FIC_EN_STAT_LO  12'h080
`define FIC_EN_STAT_HI  12'h084
`define FIC_PD_STAT_LO  12'h088
`define FIC_PD_STAT_HI  12'h08C

// ----------------------------------------
// field masks and reset values
// ----------------------------------------
`define FIC_EN_LO_MASK  32'hFFFF_5000
`define FIC_PD_LO_MASK  32'hFFFF_500C
`define FIC_HI_MASK     7'h7F
`define FIC_IMPL        39'h7F_FFFF_500C
`define FIC_FIXED_EN    39'h00_0000_000C
`define FIC_IRQ_RESET   39'h00_0000_0000
`define FIC_RESP_OKAY   2'b00
`define FIC_RESP_SLVERR 2'b10

`endif

/* src/fic_pkg.sv */
// types shared by the interrupt write-port modules
package fic_pkg;

	// read channel sequencer, one-hot
	typedef enum logic [1:0]
	{
		FIC_RD_IDLE = 2'b01,
		FIC_RD_RESP = 2'b10
	} fic_rd_state_t;

	// one bit per interrupt number 0..38
	typedef logic [38:0] fic_irq_vec_t;

endpackage

/* src/fic_axil_slave.sv */
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/100ps
`include "fic_regs.svh"

module fic_axil_slave
	import fic_pkg::*;
#(
	parameter int ADDR_W = `FIC_ADDR_W
)
(
	input  wire logic              clk_sys,       // system clock
	input  wire logic              nrst,          // async reset, low
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
	input  wire logic              s_axi_awvalid, // write address valid
	output logic                   s_axi_awready, // write address ready
	input  wire logic [31:0]       s_axi_wdata,   // write data
	input  wire logic [3:0]        s_axi_wstrb,   // byte strobes
	input  wire logic              s_axi_wvalid,  // write data valid
	output logic                   s_axi_wready,  // write data ready
	output logic [1:0]             s_axi_bresp,   // write response
	output logic                   s_axi_bvalid,  // write response valid
	input  wire logic              s_axi_bready,  // write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
	input  wire logic              s_axi_arvalid, // read address valid
	output logic                   s_axi_arready, // read address ready
	output logic [31:0]            s_axi_rdata,   // read data
	output logic [1:0]             s_axi_rresp,   // read response
	output logic                   s_axi_rvalid,  // read data valid
	input  wire logic              s_axi_rready,  // read data ready
	output logic                   wr_fire,       // register write strobe
	output logic [ADDR_W-1:0]      wr_addr,       // register write address
	output logic [31:0]            wr_data,       // strobe-masked data
	input  wire logic              wr_err,        // write address unmapped
	output logic [ADDR_W-1:0]      rd_addr,       // register read address
	input  wire logic [31:0]       rd_data,       // register read value
	input  wire logic              rd_err         // read address unmapped
);

	logic          aw_hold_reg;
	logic          w_hold_reg;
	fic_rd_state_t rd_state_reg;

	// write fires once both halves are held and no response waits
	assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
	assign rd_addr = s_axi_araddr;

	// write address channel
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_hold_reg   <= 1'b0;
			s_axi_awready <= 1'b1;
			wr_addr       <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			wr_addr       <= s_axi_awaddr;
			aw_hold_reg   <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		else if (wr_fire)
			aw_hold_reg <= 1'b0;
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_awready <= 1'b1;
	end

	// write data channel, unstrobed bytes become zero (no effect)
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			w_hold_reg   <= 1'b0;
			s_axi_wready <= 1'b1;
			wr_data      <= 32'h0000_0000;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			wr_data      <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
			                               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
			w_hold_reg   <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		else if (wr_fire)
			w_hold_reg <= 1'b0;
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_wready <= 1'b1;
	end

	// write response channel
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `FIC_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_err ? `FIC_RESP_SLVERR : `FIC_RESP_OKAY;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read sequencer, data captured at the address handshake
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_state_reg  <= FIC_RD_IDLE;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `FIC_RESP_OKAY;
		end
		else
		begin
			case (rd_state_reg)
				FIC_RD_IDLE:
					if (s_axi_arvalid)
					begin
						s_axi_rdata   <= rd_data;
						s_axi_rresp   <= rd_err ? `FIC_RESP_SLVERR : `FIC_RESP_OKAY;
						s_axi_rvalid  <= 1'b1;
						s_axi_arready <= 1'b0;
						rd_state_reg  <= FIC_RD_RESP;
					end
				FIC_RD_RESP:
					if (s_axi_rready)
					begin
						s_axi_rvalid  <= 1'b0;
						s_axi_arready <= 1'b1;
						rd_state_reg  <= FIC_RD_IDLE;
					end
				default:
					rd_state_reg <= FIC_RD_IDLE;
			endcase
		end
	end

endmodule

/* src/fic_irq_cells.sv */
// per-interrupt enable and pending state with presentation flops
`timescale 1ns/100ps
`include "fic_regs.svh"

module fic_irq_cells
	import fic_pkg::*;
#(
	parameter int           N        = `FIC_NIRQ,
	parameter logic [N-1:0] IMPL     = `FIC_IMPL,
	parameter logic [N-1:0] FIXED_EN = `FIC_FIXED_EN
)
(
	input  wire logic         clk_sys,  // system clock
	input  wire logic         nrst,     // async reset, low
	input  wire logic [N-1:0] en_set,   // enable set, one strobe per interrupt
	input  wire logic [N-1:0] en_clr,   // enable clear
	input  wire logic [N-1:0] pd_set,   // pending force
	input  wire logic [N-1:0] pd_clr,   // pending drop
	input  wire logic [N-1:0] src,      // hardware interrupt level
	output logic [N-1:0]      en_state, // enable bits
	output logic [N-1:0]      pd_state, // pending bits
	output logic [N-1:0]      irq_req   // enabled and pending
);

	genvar k;
	generate
		for (k = 0; k < N; k++)
		begin : g_cell
			// enable bit; fixed bits come up enabled after reset
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
					en_state[k] <= 1'b0;
				else if (IMPL[k] && (FIXED_EN[k] || en_set[k]))
					en_state[k] <= 1'b1; // R12
				else if (en_clr[k])
					en_state[k] <= 1'b0; // R01 R02 R03
			end

			// pending bit; a raise in the clearing cycle wins
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
					pd_state[k] <= 1'b0;
				else if (IMPL[k] && (src[k] || pd_set[k]))
					pd_state[k] <= 1'b1; // R05 R06 R07 R08
				else if (pd_clr[k])
					pd_state[k] <= 1'b0; // R09 R10 R11 R13
			end

			// presentation to the core
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
					irq_req[k] <= 1'b0;
				else
					irq_req[k] <= en_state[k] & pd_state[k]; // R14
			end
		end
	endgenerate

endmodule

/* src/fic_irq_ctrl.sv */
// top of the interrupt enable and pending write ports
//
// Functional notes
// R01: a one in bits 31..16 of the low enable-clear register disables that interrupt number.
// R02: a one in bit 14 or 12 of the low enable-clear register disables interrupt 14 or 12.
// R03: a one in bit k (0..6) of the high enable-clear register disables interrupt 32+k.
// R04: a zero written to enable-clear, pending-set or pending-clear bits changes nothing.
// R05: a one in bits 31..16 of the low pending-set register makes that interrupt pending.
// R06: a one in bit 14 or 12 of the low pending-set register makes interrupt 14 or 12 pending.
// R07: a one in bit 2 or 3 of the low pending-set register makes interrupt 2 or 3 pending.
// R08: a one in bit k (0..6) of the high pending-set register makes interrupt 32+k pending.
// R09: a one in bits 31..16 of the low pending-clear register drops that interrupt's pending state.
// R10: a one in bit 14 or 12 of the low pending-clear register drops pending of interrupt 14 or 12.
// R11: a one in bit 2 or 3 of the low pending-clear register drops pending of interrupt 2 or 3.
// R12: enable-set registers enable interrupt n for each one written to its bit; the code acts only on low bits 31..16, 14, 12 and high bits 0..6.
// R13: a one in bit k (0..6) of the high pending-clear register drops pending of interrupt 32+k.
// R14: an interrupt reaches the core only while both its enable and pending bits are set.
`timescale 1ns/100ps
`include "fic_regs.svh"

module fic_irq_ctrl
	import fic_pkg::*;
#(
	parameter int ADDR_W = `FIC_ADDR_W
)
(
	input  wire logic              clk_sys,       // system clock, 10 MHz
	input  wire logic              nrst,          // async reset, low
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
	input  wire logic              s_axi_awvalid, // write address valid
	output logic                   s_axi_awready, // write address ready
	input  wire logic [31:0]       s_axi_wdata,   // write data
	input  wire logic [3:0]        s_axi_wstrb,   // byte strobes
	input  wire logic              s_axi_wvalid,  // write data valid
	output logic                   s_axi_wready,  // write data ready
	output logic [1:0]             s_axi_bresp,   // write response
	output logic                   s_axi_bvalid,  // write response valid
	input  wire logic              s_axi_bready,  // write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
	input  wire logic              s_axi_arvalid, // read address valid
	output logic                   s_axi_arready, // read address ready
	output logic [31:0]            s_axi_rdata,   // read data
	output logic [1:0]             s_axi_rresp,   // read response
	output logic                   s_axi_rvalid,  // read data valid
	input  wire logic              s_axi_rready,  // read data ready
	input  wire logic [38:0]       irq_src,       // peripheral levels, same clock
	output logic [38:0]            irq_req,       // presented to the core
	output logic                   irq_any        // any interrupt presented
);

	// ----------------------------------------
	// internal signals
	// ----------------------------------------
	logic              wr_fire;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic              wr_err;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0]       rd_data;
	logic              rd_err;
	fic_irq_vec_t      en_set_vec;
	fic_irq_vec_t      en_clr_vec;
	fic_irq_vec_t      pd_set_vec;
	fic_irq_vec_t      pd_clr_vec;
	fic_irq_vec_t      en_state;
	fic_irq_vec_t      pd_state;
	fic_irq_vec_t      en_touch;
	fic_irq_vec_t      pd_rise_ok;
	logic              irq_live;

	// ----------------------------------------
	// bus front end
	// ----------------------------------------
	fic_axil_slave #(
		.ADDR_W (ADDR_W)
	) u_bus (
		.clk_sys       (clk_sys),
		.nrst          (nrst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_fire       (wr_fire),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_err        (wr_err),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_err        (rd_err)
	);

	// ----------------------------------------
	// write decode into per-interrupt strobes
	// ----------------------------------------
	// only ones act; zero bits and reserved bits give empty strobes
	always_comb
	begin
		en_set_vec = '0;
		en_clr_vec = '0;
		pd_set_vec = '0;
		pd_clr_vec = '0;
		wr_err     = 1'b0;
		if (wr_addr == `FIC_EN_SET_LO)
			en_set_vec = {7'h00, wr_data & `FIC_EN_LO_MASK}; // R12
		else if (wr_addr == `FIC_EN_SET_HI)
			en_set_vec = {wr_data[6:0] & `FIC_HI_MASK, 32'h0000_0000}; // R12
		else if (wr_addr == `FIC_EN_CLR_LO)
			en_clr_vec = {7'h00, wr_data & `FIC_EN_LO_MASK}; // R01 R02 R04
		else if (wr_addr == `FIC_EN_CLR_HI)
			en_clr_vec = {wr_data[6:0] & `FIC_HI_MASK, 32'h0000_0000}; // R03 R04
		else if (wr_addr == `FIC_PD_SET_LO)
			pd_set_vec = {7'h00, wr_data & `FIC_PD_LO_MASK}; // R05 R06 R07 R04
		else if (wr_addr == `FIC_PD_SET_HI)
			pd_set_vec = {wr_data[6:0] & `FIC_HI_MASK, 32'h0000_0000}; // R08 R04
		else if (wr_addr == `FIC_PD_CLR_LO)
			pd_clr_vec = {7'h00, wr_data & `FIC_PD_LO_MASK}; // R09 R10 R11 R04
		else if (wr_addr == `FIC_PD_CLR_HI)
			pd_clr_vec = {wr_data[6:0] & `FIC_HI_MASK, 32'h0000_0000}; // R13 R04
		else if (wr_addr == `FIC_EN_STAT_LO || wr_addr == `FIC_EN_STAT_HI ||
		         wr_addr == `FIC_PD_STAT_LO || wr_addr == `FIC_PD_STAT_HI)
			wr_err = 1'b0; // status words ignore writes
		else
			wr_err = 1'b1;
		if (!wr_fire)
		begin
			en_set_vec = '0;
			en_clr_vec = '0;
			pd_set_vec = '0;
			pd_clr_vec = '0;
		end
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	// write-only words read zero; status words show live state
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		if (rd_addr == `FIC_EN_STAT_LO)
			rd_data = en_state[31:0];
		else if (rd_addr == `FIC_EN_STAT_HI)
			rd_data = {25'h000_0000, en_state[38:32]};
		else if (rd_addr == `FIC_PD_STAT_LO)
			rd_data = pd_state[31:0];
		else if (rd_addr == `FIC_PD_STAT_HI)
			rd_data = {25'h000_0000, pd_state[38:32]};
		else if (rd_addr == `FIC_EN_SET_LO || rd_addr == `FIC_EN_SET_HI ||
		         rd_addr == `FIC_EN_CLR_LO || rd_addr == `FIC_EN_CLR_HI ||
		         rd_addr == `FIC_PD_SET_LO || rd_addr == `FIC_PD_SET_HI ||
		         rd_addr == `FIC_PD_CLR_LO || rd_addr == `FIC_PD_CLR_HI)
			rd_data = 32'h0000_0000;
		else
			rd_err = 1'b1;
	end

	// ----------------------------------------
	// interrupt state
	// ----------------------------------------
	fic_irq_cells #(
		.N        (`FIC_NIRQ),
		.IMPL     (`FIC_IMPL),
		.FIXED_EN (`FIC_FIXED_EN)
	) u_cells (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.en_set   (en_set_vec),
		.en_clr   (en_clr_vec),
		.pd_set   (pd_set_vec),
		.pd_clr   (pd_clr_vec),
		.src      (irq_src),
		.en_state (en_state),
		.pd_state (pd_state),
		.irq_req  (irq_req)
	);

	// summary line to the core
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			irq_any <= 1'b0;
		else
			irq_any <= |irq_req; // R14
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	assign en_touch   = en_set_vec | en_clr_vec;
	assign pd_rise_ok = pd_set_vec | irq_src;
	assign irq_live   = |(en_state & pd_state);

	default clocking cb_sys @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence s_en_clr_lo;
		wr_fire && (|en_clr_vec[31:0]);
	endsequence

	sequence s_en_clr_hi;
		wr_fire && (|en_clr_vec[38:32]);
	endsequence

	sequence s_quiet;
		!irq_live [*2];
	endsequence

	property p_en_clr_lo;
		s_en_clr_lo |=> ((en_state & $past(en_clr_vec)) == 39'h00_0000_0000);
	endproperty
	a_en_clr_lo: assert property (p_en_clr_lo) else $error("low enable clear missed"); // R01 R02

	property p_en_clr_hi;
		s_en_clr_hi |=> ((en_state & $past(en_clr_vec)) == 39'h00_0000_0000);
	endproperty
	a_en_clr_hi: assert property (p_en_clr_hi) else $error("high enable clear missed"); // R03

	property p_en_keep;
		wr_fire |=> (((en_state ^ $past(en_state)) & ~$past(en_touch) & ~`FIC_FIXED_EN) == 39'h00_0000_0000);
	endproperty
	a_en_keep: assert property (p_en_keep) else $error("enable moved without a one"); // R04

	property p_pd_keep;
		wr_fire |=> (((pd_state & ~$past(pd_state) & ~$past(pd_rise_ok)) == 39'h00_0000_0000) &&
		             ((~pd_state & $past(pd_state) & ~$past(pd_clr_vec)) == 39'h00_0000_0000));
	endproperty
	a_pd_keep: assert property (p_pd_keep) else $error("pending moved without a one"); // R04

	property p_pd_set;
		(|pd_set_vec) |=> ((pd_state & $past(pd_set_vec)) == $past(pd_set_vec));
	endproperty
	a_pd_set: assert property (p_pd_set) else $error("pending force missed"); // R05 R06 R07 R08

	property p_pd_clr;
		(|pd_clr_vec) |=> ((pd_state & $past(pd_clr_vec) & ~$past(irq_src)) == 39'h00_0000_0000);
	endproperty
	a_pd_clr: assert property (p_pd_clr) else $error("pending drop missed"); // R09 R10 R11 R13

	property p_en_set;
		(|en_set_vec) |=> ((en_state & $past(en_set_vec)) == $past(en_set_vec));
	endproperty
	a_en_set: assert property (p_en_set) else $error("enable set missed"); // R12

	property p_quiet;
		s_quiet |=> (irq_req == 39'h00_0000_0000);
	endproperty
	a_quiet: assert property (p_quiet) else $error("interrupt shown while gated"); // R14

	property p_any_cause;
		$rose(irq_any) |-> $past(irq_live, 2);
	endproperty
	a_any_cause: assert property (p_any_cause) else $error("summary rose without cause"); // R14

	property p_set_wins;
		(|(irq_src & pd_clr_vec)) |=> ((pd_state & $past(irq_src)) == ($past(irq_src) & `FIC_IMPL));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("raise lost to clear");

	property p_bresp;
		wr_fire |=> s_axi_bvalid ##0 (s_axi_bresp == ($past(wr_err) ? `FIC_RESP_SLVERR : `FIC_RESP_OKAY));
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response wrong");

	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");

	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

	property p_req_track;
		1'b1 |=> (irq_req == $past(en_state & pd_state));
	endproperty
	a_req_track: assert property (p_req_track) else $error("request not enable and pending"); // R14

	property p_any_track;
		1'b1 |=> (irq_any == $past(|irq_req));
	endproperty
	a_any_track: assert property (p_any_track) else $error("summary not or of requests"); // R14

	property p_wr_refuse;
		s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready);
	endproperty
	a_wr_refuse: assert property (p_wr_refuse) else $error("write taken while response waits");

	property p_rd_err_zero;
		s_axi_rvalid && (s_axi_rresp == `FIC_RESP_SLVERR) |-> (s_axi_rdata == 32'h0000_0000);
	endproperty
	a_rd_err_zero: assert property (p_rd_err_zero) else $error("refused read gave data");

endmodule

/* testbench/fic_core_model.sv */
// core-side model that takes up the interrupt requests it is shown
`timescale 1ns/100ps

module fic_core_model
	import fic_pkg::*;
(
	input  wire fic_irq_vec_t irq_req,   // per-number requests
	input  wire logic         irq_any,   // summary request
	input  wire logic         clk_sys,   // system clock
	input  wire logic         nrst,      // async reset, low
	output fic_irq_vec_t      seen_mask  // numbers ever taken up
);
	// ----------------------------------------
	// take-up
	// ----------------------------------------
	// the core only looks at the vector while the summary line is high
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			seen_mask <= '0;
		else if (irq_any)
			seen_mask <= seen_mask | irq_req;
	end
endmodule

/* testbench/fic_irq_ctrl_test.sv */
// register-level bench for the interrupt enable and pending write ports
`timescale 1ns/100ps
`include "fic_regs.svh"

module fic_irq_ctrl_test
	import fic_pkg::*;
;
	// ----------------------------------------
	// stimulus and tracked state
	// ----------------------------------------
	localparam fic_irq_vec_t EN_MSK   = `FIC_IMPL & ~`FIC_FIXED_EN;
	localparam logic [11:0]  BASE [4] = '{`FIC_EN_SET_LO, `FIC_EN_CLR_LO, `FIC_PD_SET_LO, `FIC_PD_CLR_LO};

	logic         clk_sys       = 1'b0;
	logic         nrst          = 1'b0;
	logic [11:0]  s_axi_awaddr  = '0;
	logic         s_axi_awvalid = 1'b0;
	logic [31:0]  s_axi_wdata   = '0;
	logic [3:0]   s_axi_wstrb   = '0;
	logic         s_axi_wvalid  = 1'b0;
	logic         s_axi_bready  = 1'b0;
	logic [11:0]  s_axi_araddr  = '0;
	logic         s_axi_arvalid = 1'b0;
	logic         s_axi_rready  = 1'b0;
	logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_any;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	logic [31:0]  s_axi_rdata, rdv;
	fic_irq_vec_t irq_src       = '0;
	fic_irq_vec_t irq_req, seen_mask, en_m, pd_m;
	int           bad_count     = 0;
	int           n_tests       = 0;
	int           n;

	// free-running 10 MHz clock
	always #50 clk_sys = ~clk_sys;

	fic_irq_ctrl i_fic_irq_ctrl
	(
		.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.irq_src, .irq_req, .irq_any
	);

	fic_core_model i_fic_core_model
	(
		.irq_req, .irq_any, .clk_sys, .nrst, .seen_mask
	);

	// ----------------------------------------
	// bus tasks and comparison
	// ----------------------------------------
	// count every compare, report a mismatch at once
	task chk(input string nm, input fic_irq_vec_t seen, input fic_irq_vec_t exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task give_verdict();
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// address and data offered together, each dropped at its own handshake
	task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", 39'(s_axi_bresp), 39'(er));
	endtask

	// read with rready held until the data is seen
	task axi_rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk("rresp", 39'(s_axi_rresp), 39'(er));
	endtask

	// write a 39-bit vector through both words of one register pair and track it
	task put(input int k, input fic_irq_vec_t v, input logic [3:0] s);
		fic_irq_vec_t vm;
		vm = v & {7'h7F, {8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		axi_wr(BASE[k], v[31:0], s, `FIC_RESP_OKAY);
		axi_wr(BASE[k] + 12'h004, {25'h0, v[38:32]}, 4'hF, `FIC_RESP_OKAY);
		case (k)
			0: en_m = en_m | (vm & EN_MSK);
			1: en_m = en_m & ~(vm & EN_MSK);
			2: pd_m = pd_m | (vm & `FIC_IMPL);
			default: pd_m = pd_m & ~(vm & `FIC_IMPL);
		endcase
	endtask

	// status words and presented requests against the tracked state
	task verify();
		axi_rd(`FIC_EN_STAT_LO, `FIC_RESP_OKAY, rdv);
		chk("en_lo", 39'(rdv), 39'(en_m[31:0]));
		axi_rd(`FIC_EN_STAT_HI, `FIC_RESP_OKAY, rdv);
		chk("en_hi", 39'(rdv), 39'(en_m[38:32]));
		axi_rd(`FIC_PD_STAT_LO, `FIC_RESP_OKAY, rdv);
		chk("pd_lo", 39'(rdv), 39'(pd_m[31:0]));
		axi_rd(`FIC_PD_STAT_HI, `FIC_RESP_OKAY, rdv);
		chk("pd_hi", 39'(rdv), 39'(pd_m[38:32]));
		repeat (2) @(posedge clk_sys);
		chk("irq_req", irq_req, en_m & pd_m);
		chk("irq_any", 39'(irq_any), 39'(|(en_m & pd_m)));
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	// reset, then walk enable-clear, pending-clear and pending-set over every interrupt number
	initial
	begin
		en_m = `FIC_FIXED_EN;
		pd_m = '0;
		repeat (8) @(posedge clk_sys);
		nrst <= 1'b1;
		verify();
		put(0, '1, 4'hF);
		verify();
		put(2, '1, 4'hF);
		verify();
		for (n = 1; n < 4; n++)
		begin
			put(n, '0, 4'hF);
			verify();
		end
		for (n = 0; n < 39; n++)
		begin
			put(1, 39'h1 << n, 4'hF);
			verify();
		end
		put(0, '1, 4'hF);
		for (n = 0; n < 39; n++)
		begin
			put(3, 39'h1 << n, 4'hF);
			verify();
		end
		for (n = 0; n < 39; n++)
		begin
			put(2, 39'h1 << n, 4'hF);
			verify();
		end
		// upper byte strobes off act as zeros
		put(3, '1, 4'h3);
		verify();
		// refused addresses leave the state alone
		axi_wr(12'h010, 32'hFFFF_FFFF, 4'hF, `FIC_RESP_SLVERR);
		axi_wr(`FIC_PD_CLR_LO + 12'h001, 32'hFFFF_FFFF, 4'hF, `FIC_RESP_SLVERR);
		// status words take writes with no effect
		axi_wr(`FIC_EN_STAT_LO, 32'hFFFF_FFFF, 4'hF, `FIC_RESP_OKAY);
		verify();
		axi_rd(12'h010, `FIC_RESP_SLVERR, rdv);
		chk("unmapped_rd", 39'(rdv), '0);
		axi_rd(`FIC_EN_CLR_LO, `FIC_RESP_OKAY, rdv);
		chk("wo_rd", 39'(rdv), '0);
		// a peripheral level pends implemented numbers only
		// a level held through a pending drop keeps its bit pending
		irq_src <= (39'h1 << 33) | (39'h1 << 5);
		put(3, '1, 4'hF);
		irq_src <= '0;
		pd_m = pd_m | (39'h1 << 33);
		verify();
		chk("core_seen", seen_mask, `FIC_IMPL);
		give_verdict();
	end

	// hang guard, well beyond the expected run
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		give_verdict();
	end
endmodule
